// ---- rtl/scsw_pkg.sv ----
// shared constants and types for the servo control switch word block
package scsw_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 16;
    localparam logic [7:0]  OFS_CTRL_WORD   = 8'h45;
    localparam logic [7:0]  OFS_SERVO_CMD   = 8'h1E;
    localparam logic [7:0]  OFS_STATUS      = 8'h46;
    localparam logic [15:0] RST_CTRL_WORD   = 16'h0001;
    localparam logic [15:0] RST_SERVO_CMD   = 16'h0000;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CW_DEV_CLR     = 0;
    localparam int CW_AUTO_PERM   = 1;
    localparam int CW_KEEP_CMD    = 2;
    localparam int CW_FILT_SEL    = 3;
    localparam int CW_ADC_AUTO_N  = 4;
    localparam int CW_KEEP_RAMP   = 5;
    localparam int CW_IDX_STYLE   = 6;
    localparam int CW_IDX_ROUTE   = 7;
    localparam int SC_OP_PERMIT   = 1;
    localparam int SC_RAMP_EN     = 7;

    localparam int POS_W          = 32;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SCSW_MODE_POS,
        SCSW_MODE_SPEED,
        SCSW_MODE_CURR
    } scsw_mode_t;

    typedef struct packed {
        logic quadFirst;
        logic quadSecond;
        logic rawIndex;
    } scsw_enc_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } scsw_bus_t;

endpackage : scsw_pkg

// ---- rtl/scsw_core.sv ----
// control switch word register and the servo behaviour it selects
// ----------------------------------------------------------------------
// How it works
// - bit 0 set clears position deviation when the servo turns off.
// - bit 1 set clears operation permission when a profile move ends.
// - bit 2 clear resets command on mode change: zero, or position.
// - bit 2 set keeps the command value across a mode change.
// - bit 2 governs second-to-first mode switches during or after servo-on.
// - position control runs only during profile operation.
// - bit 3 picks speed filter 2, only with a 17-bit sensor.
// - bit 4 clear allows automatic high-resolution analog switching.
// - bit 5 clear follows command bit 7; set applies the ramp.
// - power-off clears command bit 7; bit 5 keeps ramp behaviour.
// - bit 6 clear: index high while both quadrature outputs low.
// - bit 6 set: index high together with first quadrature high.
// - bit 7 routes index to output five, ignoring its own value.
// ----------------------------------------------------------------------
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module scsw_core
(
    input  wire logic                          clk,          // 50 MHz
    input  wire logic                          resetn,       // async, low
    input  wire scsw_pkg::scsw_bus_t           bus,          // host strobes
    output logic [scsw_pkg::DATA_W-1:0]        rdata,        // read data
    input  wire logic                          servoOn,      // servo enabled
    input  wire logic                          powerOff,     // power loss
    input  wire logic                          profileActive,// profile run
    input  wire logic                          profileDone,  // move end pulse
    input  wire scsw_pkg::scsw_mode_t          modeReq,      // wanted mode
    input  wire logic [scsw_pkg::POS_W-1:0]    presentPos,   // position
    input  wire logic [scsw_pkg::POS_W-1:0]    devDelta,     // error step
    input  wire logic                          cmdLoad,      // new command
    input  wire logic [scsw_pkg::POS_W-1:0]    cmdIn,        // command data
    input  wire logic                          sensor17,     // 17-bit sensor
    input  wire logic                          analogLow,    // low voltage
    input  wire scsw_pkg::scsw_enc_t           enc,          // encoder lines
    input  wire logic                          outFiveValue, // output 5 param
    output logic [scsw_pkg::POS_W-1:0]         posDeviation, // deviation
    output logic [scsw_pkg::POS_W-1:0]         cmdValue,     // command value
    output scsw_pkg::scsw_mode_t               activeMode,   // applied mode
    output logic                               posLoopEn,    // position loop
    output logic                               speedFilt2,   // filter 2 sel
    output logic                               analogHiRes,  // hi-res path
    output logic                               rampEn,       // speed ramp
    output logic                               quadrature_out_first, // ch A
    output logic                               quadrature_out_second, // ch B
    output logic                               indexOut,     // index pulse
    output logic                               general_output_five // out 5
);
    import scsw_pkg::*;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] ctrlWord_q;
    logic [DATA_W-1:0] servoCmd_q;
    logic [DATA_W-1:0] servoCmd_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              servoOn_q;
    logic              idxStyle_q;
    logic [POS_W-1:0]  posDev_q;
    logic [POS_W-1:0]  posDev_d;
    logic [POS_W-1:0]  cmd_q;
    logic [POS_W-1:0]  cmd_d;
    scsw_mode_t        mode_q;
    scsw_mode_t        modeEff;
    logic              quadA_q;
    logic              quadB_q;
    logic              index_q;
    logic              index_d;
    logic              outFive_q;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire wrCtrl     = bus.wr && (bus.addr == OFS_CTRL_WORD);
    wire wrServoCmd = bus.wr && (bus.addr == OFS_SERVO_CMD);
    wire rdCtrl     = bus.rd && (bus.addr == OFS_CTRL_WORD);
    wire rdServoCmd = bus.rd && (bus.addr == OFS_SERVO_CMD);
    wire rdStatus   = bus.rd && (bus.addr == OFS_STATUS);
    wire servoOffEdge = servoOn_q && !servoOn;
    wire devClrSel    = ctrlWord_q[CW_DEV_CLR];
    wire autoPermSel  = ctrlWord_q[CW_AUTO_PERM];
    wire keepCmdSel   = ctrlWord_q[CW_KEEP_CMD];
    wire keepRampSel  = ctrlWord_q[CW_KEEP_RAMP];
    wire idxRouteSel  = ctrlWord_q[CW_IDX_ROUTE];

    wire [DATA_W-1:0] statusWord = {
        8'h00,
        servoOn_q,
        posLoopEn,
        mode_q,
        speedFilt2,
        analogHiRes,
        rampEn,
        idxStyle_q
    };

    // ------------------------------------------------------------------
    // host register access
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ctrlWord_q <= RST_CTRL_WORD;
        else if (wrCtrl)
            ctrlWord_q <= bus.wdata;
    end

    // unmapped reads answer zero; data stand for one cycle only
    assign rdata_d = rdCtrl     ? ctrlWord_q :
                     rdServoCmd ? servoCmd_q :
                     rdStatus   ? statusWord : 16'h0000;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rdata_q <= 16'h0000;
        else
            rdata_q <= rdata_d;
    end

    assign rdata = rdata_q;

    // ------------------------------------------------------------------
    // servo command word: permission and ramp bits
    // ------------------------------------------------------------------
    // a host write in the same cycle as a move end wins, so a fresh
    // permission given at that moment is not lost
    always_comb
    begin
        servoCmd_d = servoCmd_q;
        if (profileDone && autoPermSel)
            servoCmd_d[SC_OP_PERMIT] = 1'b0;
        if (powerOff)
            servoCmd_d[SC_RAMP_EN] = 1'b0;
        if (wrServoCmd)
            servoCmd_d = bus.wdata;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            servoCmd_q <= RST_SERVO_CMD;
        else
            servoCmd_q <= servoCmd_d;
    end

    // ------------------------------------------------------------------
    // position deviation
    // ------------------------------------------------------------------
    assign posDev_d = (servoOffEdge && devClrSel) ? '0 :
                      servoOn ? posDev_q + devDelta : posDev_q;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            posDev_q  <= '0;
            servoOn_q <= 1'b0;
        end
        else
        begin
            posDev_q  <= posDev_d;
            servoOn_q <= servoOn;
        end
    end

    assign posDeviation = posDev_q;

    // ------------------------------------------------------------------
    // control mode and command value
    // ------------------------------------------------------------------
    // a position request outside a profile run is served in speed mode
    assign modeEff = (modeReq == SCSW_MODE_POS && !profileActive) ?
                     SCSW_MODE_SPEED : modeReq;
    wire modeChange = (modeEff != mode_q);

    // every mode change, including second back to first, obeys bit 2
    always_comb
    begin
        cmd_d = cmd_q;
        if (modeChange && !keepCmdSel)
            cmd_d = (modeEff == SCSW_MODE_POS) ? presentPos : '0;
        else if (cmdLoad)
            cmd_d = cmdIn;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_q <= SCSW_MODE_SPEED;
            cmd_q  <= '0;
        end
        else
        begin
            mode_q <= modeEff;
            cmd_q  <= cmd_d;
        end
    end

    assign cmdValue   = cmd_q;
    assign activeMode = mode_q;
    assign posLoopEn  = servoOn_q && (mode_q == SCSW_MODE_POS);

    // ------------------------------------------------------------------
    // filter, analog range and ramp selection
    // ------------------------------------------------------------------
    assign speedFilt2  = ctrlWord_q[CW_FILT_SEL] && sensor17;
    assign analogHiRes = !ctrlWord_q[CW_ADC_AUTO_N] && analogLow;
    assign rampEn      = (mode_q == SCSW_MODE_SPEED) &&
                         (keepRampSel || servoCmd_q[SC_RAMP_EN]);

    // ------------------------------------------------------------------
    // index pulse shaping and output five
    // ------------------------------------------------------------------
    // the style is sampled only while the servo is off, so a late host
    // change cannot glitch the index during motor control
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            idxStyle_q <= 1'b0;
        else if (!servoOn)
            idxStyle_q <= ctrlWord_q[CW_IDX_STYLE];
    end

    assign index_d = idxStyle_q ?
                     (enc.rawIndex && enc.quadFirst) :
                     (enc.rawIndex && !enc.quadFirst && !enc.quadSecond);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            quadA_q   <= 1'b0;
            quadB_q   <= 1'b0;
            index_q   <= 1'b0;
            outFive_q <= 1'b0;
        end
        else
        begin
            quadA_q   <= enc.quadFirst;
            quadB_q   <= enc.quadSecond;
            index_q   <= index_d;
            outFive_q <= idxRouteSel ? index_d : outFiveValue;
        end
    end

    assign quadrature_out_first  = quadA_q;
    assign quadrature_out_second = quadB_q;
    assign indexOut              = index_q;
    assign general_output_five   = outFive_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence servoDrop;
        $fell(servoOn) && devClrSel;
    endsequence

    chk_dev_clear_off: assert property (
        servoDrop |=> posDeviation == '0)
        else $error("deviation not cleared at servo off");

    chk_dev_kept_off: assert property (
        $fell(servoOn) && !devClrSel |=> $stable(posDeviation))
        else $error("deviation changed at servo off");

    chk_perm_autoclr: assert property (
        profileDone && autoPermSel && !wrServoCmd
        |=> !servoCmd_q[SC_OP_PERMIT])
        else $error("permission not cleared after move");

    chk_cmd_reset_mode: assert property (
        modeChange && !keepCmdSel && modeEff != SCSW_MODE_POS
        |=> cmdValue == '0)
        else $error("command not zeroed on mode change");

    chk_cmd_keep_mode: assert property (
        modeChange && keepCmdSel && !cmdLoad |=> $stable(cmdValue))
        else $error("command changed with keep selected");

    chk_pos_profile: assert property (
        posLoopEn |-> $past(profileActive))
        else $error("position loop outside profile");

    chk_ramp_follow: assert property (
        mode_q == SCSW_MODE_SPEED && !keepRampSel
        |-> rampEn == servoCmd_q[SC_RAMP_EN])
        else $error("ramp does not follow command bit");

    chk_ramp_power: assert property (
        powerOff && !wrServoCmd |=> !servoCmd_q[SC_RAMP_EN])
        else $error("ramp bit kept over power off");

    sequence idxLowLow;
        !idxStyle_q && enc.rawIndex && !enc.quadFirst && !enc.quadSecond;
    endsequence

    chk_idx_low_style: assert property (
        idxLowLow |=> indexOut)
        else $error("index missing with both lines low");

    chk_idx_sync_style: assert property (
        idxStyle_q && !enc.quadFirst |=> !indexOut)
        else $error("index high without first line");

    chk_general_output_five_route: assert property (
        idxRouteSel && !wrCtrl |=> general_output_five == indexOut)
        else $error("output five not carrying index");

    chk_word_write: assert property (
        wrCtrl ##1 bus.rd && bus.addr == OFS_CTRL_WORD
        |=> rdata == $past(bus.wdata, 2))
        else $error("control word readback wrong");

endmodule : scsw_core

`default_nettype wire

// ---- testbench/scsw_host_model.sv ----
// host controller model that writes and reads drive parameters
`timescale 1ns/10ps
`default_nettype none

module scsw_host_model
    import scsw_pkg::*;
(
    input  wire logic                   clk,   // bench clock
    output scsw_pkg::scsw_bus_t         bus,   // host strobes
    input  wire logic [DATA_W-1:0]      rdata  // read data
);
    import scsw_pkg::*;

    initial bus = '{addr: 8'hFF, wdata: 16'hFFFF, wr: 1'b0, rd: 1'b0};

    // ------------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------------
    // idle fields show the inverse of the last value so no stale data
    // can pass for a real transfer
    task automatic write_word(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : write_word

    // read data stand only in the cycle after the strobe, so they are
    // taken mid-cycle, away from the edge that launches them
    task automatic read_word(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '{addr: ~a, wdata: 16'hFFFF, wr: 1'b0, rd: 1'b0};
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask : read_word

    // write followed at once by a read of the same word, no gap
    task automatic write_read(input logic [7:0] a, input logic [15:0] d,
                              output logic [15:0] q);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '{addr: a, wdata: ~d, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '{addr: ~a, wdata: d, wr: 1'b0, rd: 1'b0};
        @(negedge clk);
        q = rdata;
        @(posedge clk);
    endtask : write_read

endmodule : scsw_host_model

`default_nettype wire

// ---- testbench/servo_control_switch_word_tb.sv ----
// self-checking bench for the control switch word block
`timescale 1ns/10ps
`default_nettype none

module servo_control_switch_word_tb;
    import scsw_pkg::*;

    logic              clk;
    logic              resetn;
    scsw_bus_t         bus;
    logic [DATA_W-1:0] rdata;
    logic              servoOn, powerOff, profileActive, profileDone;
    scsw_mode_t        modeReq, activeMode;
    logic [POS_W-1:0]  presentPos, devDelta, cmdIn, posDeviation, cmdValue;
    logic              cmdLoad, sensor17, analogLow, outFiveValue;
    scsw_enc_t         enc;
    logic              posLoopEn, speedFilt2, analogHiRes, rampEn;
    logic              qFirst, qSecond, indexOut, outFive;
    logic [15:0]       rd;
    int                errors, cmp_count, cycles;

    // ------------------------------------------------------------------
    // clock, instances
    // ------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    scsw_host_model scsw_host_model_i (.clk(clk), .bus(bus), .rdata(rdata));

    scsw_core scsw_core_i (
        .clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
        .servoOn(servoOn), .powerOff(powerOff),
        .profileActive(profileActive), .profileDone(profileDone),
        .modeReq(modeReq), .presentPos(presentPos), .devDelta(devDelta),
        .cmdLoad(cmdLoad), .cmdIn(cmdIn), .sensor17(sensor17),
        .analogLow(analogLow), .enc(enc), .outFiveValue(outFiveValue),
        .posDeviation(posDeviation), .cmdValue(cmdValue),
        .activeMode(activeMode), .posLoopEn(posLoopEn),
        .speedFilt2(speedFilt2), .analogHiRes(analogHiRes),
        .rampEn(rampEn), .quadrature_out_first(qFirst),
        .quadrature_out_second(qSecond), .indexOut(indexOut),
        .general_output_five(outFive));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic cw(input logic [15:0] v);
        scsw_host_model_i.write_word(OFS_CTRL_WORD, v);
    endtask : cw

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [15:0] exp);
        scsw_host_model_i.read_word(a, rd);
        check(nm, {16'h0000, rd}, {16'h0000, exp});
    endtask : rd_chk

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // a hang must still reach the closing report
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            test_done();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        errors = 0; cmp_count = 0; cycles = 0;
        resetn = 1'b0; servoOn = 1'b0; powerOff = 1'b0;
        profileActive = 1'b0; profileDone = 1'b0; modeReq = SCSW_MODE_SPEED;
        presentPos = 32'h0000_0000; devDelta = 32'h0000_0003;
        cmdLoad = 1'b0; cmdIn = 32'h0000_0000; sensor17 = 1'b0;
        analogLow = 1'b0; outFiveValue = 1'b0; enc = '0;
        tick(4);
        resetn <= 1'b1;
        rd_chk("ctrl reset", OFS_CTRL_WORD, RST_CTRL_WORD);
        scsw_host_model_i.write_read(OFS_CTRL_WORD, 16'h00A5, rd);
        check("ctrl rw", {16'h0000, rd}, 32'h0000_00A5);
        rd_chk("unmapped", 8'h10, 16'h0000);
        // deviation kept, then cleared on servo off
        cw(16'h0000);
        servoOn <= 1'b1;
        tick(4);
        servoOn <= 1'b0;
        tick(2);
        check("dev kept", posDeviation, 32'h0000_000C);
        cw(16'h0001);
        servoOn <= 1'b1;
        tick(2);
        servoOn <= 1'b0;
        tick(2);
        check("dev clear", posDeviation, 32'h0000_0000);
        // command reset and keep on mode change
        cw(16'h0000);
        servoOn <= 1'b1;
        cmdIn <= 32'h0000_1234;
        cmdLoad <= 1'b1;
        tick(1);
        cmdLoad <= 1'b0;
        tick(1);
        check("cmd load", cmdValue, 32'h0000_1234);
        modeReq <= SCSW_MODE_CURR;
        tick(2);
        check("cmd curr", cmdValue, 32'h0000_0000);
        presentPos <= 32'h0000_0777;
        profileActive <= 1'b1;
        modeReq <= SCSW_MODE_POS;
        tick(2);
        check("cmd pos", cmdValue, 32'h0000_0777);
        check("mode pos", activeMode, SCSW_MODE_POS);
        check("pos loop", posLoopEn, 1'b1);
        profileActive <= 1'b0;
        tick(2);
        check("no profile", activeMode, SCSW_MODE_SPEED);
        check("pos loop off", posLoopEn, 1'b0);
        cw(16'h0004);
        cmdIn <= 32'h0000_0055;
        cmdLoad <= 1'b1;
        tick(1);
        cmdLoad <= 1'b0;
        modeReq <= SCSW_MODE_CURR;
        tick(2);
        check("cmd keep", cmdValue, 32'h0000_0055);
        modeReq <= SCSW_MODE_SPEED;
        tick(2);
        check("cmd keep back", cmdValue, 32'h0000_0055);
        // permission cleared at move end only when enabled
        for (int k = 0; k < 2; k++)
        begin
            cw(k ? 16'h0002 : 16'h0000);
            scsw_host_model_i.write_word(OFS_SERVO_CMD, 16'h0002);
            profileDone <= 1'b1;
            tick(1);
            profileDone <= 1'b0;
            rd_chk("permit", OFS_SERVO_CMD, k ? 16'h0000 : 16'h0002);
        end
        // speed filter and analog resolution
        for (int k = 0; k < 4; k++)
        begin
            sensor17 <= k[0];
            analogLow <= k[0];
            cw({11'h000, k[1], k[1], 3'h0});
            tick(1);
            check("filt2", speedFilt2, k[1] & k[0]);
            check("hires", analogHiRes, !k[1] & k[0]);
        end
        // ramp selection and power-off clear
        cw(16'h0000);
        scsw_host_model_i.write_word(OFS_SERVO_CMD, 16'h0080);
        tick(2);
        check("ramp cmd", rampEn, 1'b1);
        scsw_host_model_i.write_word(OFS_SERVO_CMD, 16'h0000);
        tick(2);
        check("ramp off", rampEn, 1'b0);
        cw(16'h0020);
        tick(2);
        check("ramp keep", rampEn, 1'b1);
        scsw_host_model_i.write_word(OFS_SERVO_CMD, 16'h0080);
        powerOff <= 1'b1;
        tick(1);
        powerOff <= 1'b0;
        rd_chk("pwr clear", OFS_SERVO_CMD, 16'h0000);
        check("ramp pwr", rampEn, 1'b1);
        // servo on, speed mode, hi-res path and ramp active
        rd_chk("status", OFS_STATUS, 16'h0096);
        // index style changed only with the servo off
        servoOn <= 1'b0;
        outFiveValue <= 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            cw({8'h00, 1'b1, k[2], 6'h00});
            enc <= '{quadFirst: k[0], quadSecond: k[1], rawIndex: 1'b1};
            tick(3);
            check("idx", indexOut, k[2] ? k[0] : !k[0] & !k[1]);
            check("general_output_five idx", outFive, k[2] ? k[0] : !k[0] & !k[1]);
            check("quad1", qFirst, k[0]);
            check("quad2", qSecond, k[1]);
        end
        cw(16'h0000);
        for (int k = 0; k < 2; k++)
        begin
            outFiveValue <= k[0];
            tick(2);
            check("general_output_five val", outFive, k[0]);
        end
        test_done();
    end

endmodule : servo_control_switch_word_tb

`default_nettype wire
